// File: design/bbc_decode.sv
/*
  Decode and execute unit for conditional relative branches, bit test and
  branch, bit set/clear, control instructions and extended jump/call.
  Assumes the fetch logic presents all instruction bytes with start_i while
  busy_o is low, that data reads answer on the cycle after mem_rd_o, and
  that the stack logic answers a pop on ret_* before done_o.
*/
// Contract
// - Relative branch jumps only on carry/no carry/zero/nonzero, else falls through.
// - Short branch displacement is 5-bit signed, reach -15 to +16.
// - Branch-if-bit-clear tests data bit, branches on 0; 3 bytes, 5 cycles.
// - Branch-if-bit-set tests data bit, branches on 1; 3 bytes, 5 cycles.
// - Bit test branch uses 8-bit signed displacement, reach -126 to +129.
// - Bit test branch copies tested bit into carry; zero stays.
// - Bit set/clear: bit direct, 2 bytes, 4 cycles, flags untouched.
// - Any bit of any data byte; 3-bit opcode field picks the bit.
// - Control ops are one byte, two cycles; only interrupt return sets flags.
// - With watchdog selected, stop acts as a wait.
// - Jump and call take 12-bit target; 2 bytes, 4 cycles, flags kept.
// - Extended target joins four opcode bits as upper part with next byte.
// - Short branch opcode holds condition, direction and four span bits.
`timescale 1ns/1ps

module bbc_decode
  import bbc_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            start_i,
  input  wire logic [7:0]      opcode_i,
  input  wire logic [7:0]      operand1_i,
  input  wire logic [7:0]      operand2_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic            carry_i,
  input  wire logic            zero_i,
  input  wire logic            watchdog_sel_i,
  input  wire logic [7:0]      mem_rdata_i,
  input  wire logic [PC_W-1:0] ret_addr_i,
  input  wire logic            ret_carry_i,
  input  wire logic            ret_zero_i,
  output logic                 busy_o,
  output logic                 done_o,
  output logic [PC_W-1:0]      pc_next_o,
  output logic                 carry_o,
  output logic                 zero_o,
  output logic                 flags_we_o,
  output logic                 mem_rd_o,
  output logic                 mem_we_o,
  output logic [7:0]           mem_addr_o,
  output logic [7:0]           mem_wdata_o,
  output logic                 push_o,
  output logic [PC_W-1:0]      push_addr_o,
  output logic                 pop_o,
  output logic                 stop_o,
  output logic                 wait_o,
  output logic                 unsupported_o
);

  // Bit select field is stored in reversed order in opcode bits [7:5]
  function automatic logic [2:0] bit_sel(input logic [7:0] op);
    bit_sel = {op[5], op[6], op[7]};
  endfunction : bit_sel

  // Program counter plus base plus signed displacement, modulo 4K
  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc,
                                             input logic [PC_W-1:0] base,
                                             input logic [7:0]      disp);
    pc_rel = pc + base + {{(PC_W-8){disp[7]}}, disp};
  endfunction : pc_rel

  bbc_state_t      state_q;
  bbc_kind_t       kind_d;
  bbc_kind_t       kind_q;
  logic [2:0]      total_d;
  logic [2:0]      total_q;
  logic [2:0]      el_q;
  logic [7:0]      op_q;
  logic [7:0]      arg1_q;
  logic [7:0]      arg2_q;
  logic [PC_W-1:0] pc_q;
  logic            carry_q;
  logic            zero_q;
  logic            wd_q;
  logic            tbit_q;
  logic            accept;
  logic            fin;
  logic            cond_met;
  logic [7:0]      rel_disp;

  assign accept = (state_q == BBC_IDLE) && start_i;
  assign fin    = (state_q == BBC_RUN) && (el_q == total_q - 3'h1);

  // Family decode from the low opcode bits
  always_comb begin
    kind_d  = K_BAD;
    total_d = CYC_CTL;
    unique case (opcode_i[2:0])
      COND_NZ, COND_NC, COND_Z, COND_C: begin
        kind_d  = K_REL;
        total_d = CYC_REL;
      end
      FAM_EXT: begin
        kind_d  = opcode_i[3] ? K_JUMP : K_CALL;
        total_d = CYC_EXT;
      end
      FAM_BITS: begin
        kind_d  = opcode_i[3] ? K_BIT : K_BTST;
        total_d = opcode_i[3] ? CYC_BIT : CYC_BTST;
      end
      FAM_CTL: begin
        if (opcode_i[3] && opcode_i[7:4] <= CTL_WAIT) begin
          kind_d  = K_CTL;
          total_d = CYC_CTL;
        end
      end
      default: begin
        kind_d  = K_BAD;
        total_d = CYC_CTL;
      end
    endcase
  end

  // Sequencer: one pass per instruction, elapsed-cycle count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= BBC_IDLE;
      el_q    <= 3'h0;
      busy_o  <= 1'b0;
    end else if (accept) begin
      state_q <= BBC_RUN;
      el_q    <= 3'h1;
      busy_o  <= 1'b1;
    end else if (fin) begin
      state_q <= BBC_IDLE;
      el_q    <= 3'h0;
      busy_o  <= 1'b0;
    end else if (state_q == BBC_RUN) begin
      el_q <= el_q + 3'h1;
    end
  end

  // Instruction bytes and flags captured on acceptance
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_q  <= K_BAD;
      total_q <= CYC_CTL;
      op_q    <= 8'h00;
      arg1_q  <= 8'h00;
      arg2_q  <= 8'h00;
      pc_q    <= PC_RST;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
      wd_q    <= 1'b0;
    end else if (accept) begin
      kind_q  <= kind_d;
      total_q <= total_d;
      op_q    <= opcode_i;
      arg1_q  <= operand1_i;
      arg2_q  <= operand2_i;
      pc_q    <= pc_i;
      carry_q <= carry_i;
      zero_q  <= zero_i;
      wd_q    <= watchdog_sel_i;
    end
  end

  // Data space access for bit test and bit set/clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_o    <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 8'h00;
      mem_wdata_o <= 8'h00;
      tbit_q      <= 1'b0;
    end else begin
      mem_rd_o <= accept && (kind_d == K_BTST || kind_d == K_BIT);
      mem_we_o <= 1'b0;
      if (accept) begin
        mem_addr_o <= operand1_i;
      end
      if (state_q == BBC_RUN && el_q == RD_PHASE) begin
        tbit_q <= mem_rdata_i[bit_sel(op_q)];
        if (kind_q == K_BIT) begin
          mem_we_o    <= 1'b1;
          mem_wdata_o <= mem_rdata_i;
          mem_wdata_o[bit_sel(op_q)] <= op_q[4];
        end
      end
    end
  end

  // Subroutine stack requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_o      <= 1'b0;
      push_addr_o <= PC_RST;
      pop_o       <= 1'b0;
    end else begin
      push_o <= accept && kind_d == K_CALL;
      pop_o  <= accept && kind_d == K_CTL &&
                (opcode_i[7:4] == CTL_RET || opcode_i[7:4] == CTL_INTERRUPT_RETURN);
      if (accept) begin
        push_addr_o <= pc_i + LEN_2;
      end
    end
  end

  // Short branch: sign in bit 3, span in high nibble
  assign rel_disp = {{4{op_q[3]}}, op_q[7:4]};

  // Condition evaluation for the four short branches
  always_comb begin
    cond_met = 1'b0;
    unique case (op_q[2:0])
      COND_NZ: cond_met = !zero_q;
      COND_NC: cond_met = !carry_q;
      COND_Z:  cond_met = zero_q;
      COND_C:  cond_met = carry_q;
      default: cond_met = 1'b0;
    endcase
  end

  // Completion: next program counter, flags and power requests
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o        <= 1'b0;
      pc_next_o     <= PC_RST;
      carry_o       <= 1'b0;
      zero_o        <= 1'b0;
      flags_we_o    <= 1'b0;
      stop_o        <= 1'b0;
      wait_o        <= 1'b0;
      unsupported_o <= 1'b0;
    end else begin
      done_o        <= fin;
      flags_we_o    <= 1'b0;
      stop_o        <= 1'b0;
      wait_o        <= 1'b0;
      unsupported_o <= 1'b0;
      if (fin) begin
        carry_o <= carry_q;
        zero_o  <= zero_q;
        unique case (kind_q)
          K_REL: begin
            pc_next_o <= cond_met ? pc_rel(pc_q, REL_BASE, rel_disp)
                                  : pc_q + LEN_1;
          end
          K_CALL, K_JUMP: begin
            pc_next_o <= {op_q[7:4], arg1_q};
          end
          K_BTST: begin
            pc_next_o <= (tbit_q == op_q[4])
                         ? pc_rel(pc_q, BTST_BASE, arg2_q)
                         : pc_q + LEN_3;
            carry_o    <= tbit_q;
            flags_we_o <= 1'b1;
          end
          K_BIT: begin
            pc_next_o <= pc_q + LEN_2;
          end
          K_CTL: begin
            pc_next_o <= pc_q + LEN_1;
            unique case (op_q[7:4])
              CTL_RET: pc_next_o <= ret_addr_i;
              CTL_INTERRUPT_RETURN: begin
                pc_next_o  <= ret_addr_i;
                carry_o    <= ret_carry_i;
                zero_o     <= ret_zero_i;
                flags_we_o <= 1'b1;
              end
              CTL_STOP: begin
                stop_o <= !wd_q;
                wait_o <= wd_q;
              end
              CTL_WAIT: wait_o <= 1'b1;
              default:  pc_next_o <= pc_q + LEN_1;
            endcase
          end
          default: begin
            pc_next_o     <= pc_q + LEN_1;
            unsupported_o <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : bbc_decode

// File: design/bbc_pkg.sv
/*
  Constants and types for the branch, bit and control decode/execute block.
  Assumes an 8-bit opcode byte, a 12-bit program counter and a 256-byte
  data space reached through a simple read/write strobe interface.
*/
package bbc_pkg;

  // Widths
  localparam int unsigned PC_W = 12;

  // Family codes in opcode bits [2:0]
  localparam logic [2:0] COND_NZ  = 3'h0; // Zero clear
  localparam logic [2:0] FAM_EXT  = 3'h1; // Bit 3: 0 call, 1 long jump
  localparam logic [2:0] COND_NC  = 3'h2; // Carry clear
  localparam logic [2:0] FAM_BITS = 3'h3; // Bit 3: 0 test branch, 1 set/clear
  localparam logic [2:0] COND_Z   = 3'h4; // Zero set
  localparam logic [2:0] FAM_CTL  = 3'h5; // Bit 3 high: control group
  localparam logic [2:0] COND_C   = 3'h6; // Carry set

  // Control instructions, selected by the high nibble of a 1101 low nibble
  localparam logic [3:0] CTL_NOP  = 4'h0;
  localparam logic [3:0] CTL_RET  = 4'h1;
  localparam logic [3:0] CTL_INTERRUPT_RETURN = 4'h2;
  localparam logic [3:0] CTL_STOP = 4'h3;
  localparam logic [3:0] CTL_WAIT = 4'h4;

  // Cycle counts per instruction kind
  localparam logic [2:0] CYC_REL  = 3'h2;
  localparam logic [2:0] CYC_BTST = 3'h5;
  localparam logic [2:0] CYC_BIT  = 3'h4;
  localparam logic [2:0] CYC_CTL  = 3'h2;
  localparam logic [2:0] CYC_EXT  = 3'h4;

  // Cycle in which read data is present on the data bus
  localparam logic [2:0] RD_PHASE = 3'h2;

  // Instruction lengths and displacement bases
  localparam logic [PC_W-1:0] LEN_1     = 12'h001;
  localparam logic [PC_W-1:0] LEN_2     = 12'h002;
  localparam logic [PC_W-1:0] LEN_3     = 12'h003;
  localparam logic [PC_W-1:0] REL_BASE  = 12'h001;
  localparam logic [PC_W-1:0] BTST_BASE = 12'h002;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 12'h000;

  typedef enum logic {
    BBC_IDLE,
    BBC_RUN
  } bbc_state_t;

  typedef enum logic [2:0] {
    K_REL,
    K_CALL,
    K_JUMP,
    K_BTST,
    K_BIT,
    K_CTL,
    K_BAD
  } bbc_kind_t;

endpackage : bbc_pkg

// File: dv/bbc_decode_props.sv
/*
  Port checker for bbc_decode: timing, targets and flags.
  Assumes bbc_pkg is compiled first; bound to every bbc_decode.
*/
`timescale 1ns/1ps
module bbc_decode_props
  import bbc_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  input wire logic            start_i,
  input wire logic [7:0]      opcode_i,
  input wire logic [7:0]      operand1_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic            carry_i,
  input wire logic            zero_i,
  input wire logic            watchdog_sel_i,
  input wire logic            busy_o,
  input wire logic            done_o,
  input wire logic [PC_W-1:0] pc_next_o,
  input wire logic            carry_o,
  input wire logic            zero_o,
  input wire logic            flags_we_o,
  input wire logic            mem_we_o,
  input wire logic [7:0]      mem_addr_o,
  input wire logic            push_o,
  input wire logic [PC_W-1:0] push_addr_o,
  input wire logic            stop_o,
  input wire logic            wait_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Request taken, and the opcode nibble used for long targets
  logic       acc;
  logic [3:0] op_hi;
  assign acc   = start_i && !busy_o;
  assign op_hi = opcode_i[7:4];

  AST_REL_FALL: assert property (acc && opcode_i[2:0] == 3'h4 &&
    !zero_i |-> ##2 done_o && pc_next_o == $past(pc_i, 2) + 12'h001)
    else $error("branch fall-through wrong");
  AST_REL_BACK: assert property (acc && opcode_i == 8'h08 &&
    !zero_i |-> ##2 done_o && pc_next_o == $past(pc_i, 2) - 12'h00f)
    else $error("backward reach wrong");
  AST_BTST_TIME: assert property (acc && opcode_i[3:0] == 4'h3
    |-> ##5 done_o && flags_we_o) else $error("bit test length wrong");
  AST_BTST_ZERO: assert property (acc && opcode_i[3:0] == 4'h3
    |-> ##5 zero_o == $past(zero_i, 5)) else $error("zero flag moved");
  AST_BIT_WRITE: assert property (acc && opcode_i[3:0] == 4'hb
    |-> ##3 mem_we_o && mem_addr_o == $past(operand1_i, 3))
    else $error("bit write wrong");
  AST_BIT_FLAGS: assert property (acc && opcode_i[3:0] == 4'hb
    |-> ##4 done_o && !flags_we_o && carry_o == $past(carry_i, 4))
    else $error("bit op timing or flags wrong");
  AST_CTL_NOP: assert property (acc && opcode_i == 8'h0d
    |-> ##2 done_o && !flags_we_o && pc_next_o == $past(pc_i, 2) + 12'h001)
    else $error("no-op wrong");
  AST_WD_STOP: assert property (acc && opcode_i == 8'h3d &&
    watchdog_sel_i |-> ##2 wait_o && !stop_o) else $error("stop not waited");
  AST_EXT_TGT: assert property (acc && opcode_i[2:0] == 3'h1
    |-> ##4 done_o && pc_next_o == {$past(op_hi, 4), $past(operand1_i, 4)})
    else $error("long target wrong");
  AST_CALL_PUSH: assert property (acc && opcode_i[3:0] == 4'h1
    |=> push_o && push_addr_o == $past(pc_i) + 12'h002)
    else $error("call push wrong");

  // Main scenarios reached
  cover property (acc && opcode_i[3:0] == 4'h3);
  cover property (done_o && wait_o);
  cover property (push_o);
endmodule : bbc_decode_props

bind bbc_decode bbc_decode_props u_props (.clk_i, .rst_n_i, .start_i,
  .opcode_i, .operand1_i, .pc_i, .carry_i, .zero_i, .watchdog_sel_i,
  .busy_o, .done_o, .pc_next_o, .carry_o, .zero_o, .flags_we_o, .mem_we_o,
  .mem_addr_o, .push_o, .push_addr_o, .stop_o, .wait_o);

// File: dv/test_branch_bit_control_decode.sv
/*
  Self-checking bench for bbc_decode, one task per instruction group.
  Assumes bbc_pkg; memory byte and return data are held constant.
*/
`timescale 1ns/1ps
module test_branch_bit_control_decode import bbc_pkg::*;;
  logic            clk_i, rst_n_i, start_i, carry_i, zero_i, watchdog_sel_i;
  logic            ret_carry_i, ret_zero_i, busy_o, done_o, carry_o, zero_o;
  logic            flags_we_o, mem_rd_o, mem_we_o, push_o, pop_o, stop_o;
  logic            wait_o, unsupported_o, busy_p;
  logic [7:0]      opcode_i, operand1_i, operand2_i, mem_rdata_i;
  logic [7:0]      mem_addr_o, mem_wdata_o, seen_p;
  logic [PC_W-1:0] pc_i, ret_addr_i, pc_next_o, push_addr_o;
  int              bad_count, total_checks, cyc, ncyc;

  bbc_decode uut (.clk_i, .rst_n_i, .start_i, .opcode_i, .operand1_i,
    .operand2_i, .pc_i, .carry_i, .zero_i, .watchdog_sel_i, .mem_rdata_i,
    .ret_addr_i, .ret_carry_i, .ret_zero_i, .busy_o, .done_o, .pc_next_o,
    .carry_o, .zero_o, .flags_we_o, .mem_rd_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .push_o, .push_addr_o, .pop_o, .stop_o, .wait_o,
    .unsupported_o);

  // 50 MHz clock and a hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check_val(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // One instruction; counts cycles to done and gathers pulses
  task automatic exec(input logic [7:0] op, a, d, input logic c, z, w);
    @(negedge clk_i);
    opcode_i = op;
    operand1_i = a;
    operand2_i = d;
    carry_i = c;
    zero_i = z;
    watchdog_sel_i = w;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    busy_p = busy_o;
    seen_p = 8'h00;
    for (ncyc = 1; ncyc < 20 && done_o !== 1'b1; ncyc++) begin
      seen_p |= {mem_rd_o, unsupported_o, pop_o, flags_we_o, wait_o, stop_o,
                 push_o, mem_we_o};
      @(negedge clk_i);
    end
    seen_p |= {mem_rd_o, unsupported_o, pop_o, flags_we_o, wait_o, stop_o,
               push_o, mem_we_o};
  endtask : exec

  task automatic t_rel();
    logic [1:0] i;
    logic       f;
    for (int k = 0; k < 16; k++) begin
      i = k[1:0];
      f = k[3];
      exec(k[2] ? {5'h01, i, 1'b0} : {5'h1e, i, 1'b0}, 8'h00, 8'h00,
           i[0] ? f : ~f, i[0] ? ~f : f, 1'b0);
      check_val(pc_next_o, (f != i[1]) ? 12'h201 :
                k[2] ? 12'h1f1 : 12'h210);
      check_val(ncyc[7:0], 8'h02);
    end
  endtask : t_rel

  task automatic t_btst();
    logic [2:0] b;
    logic       s;
    logic       t;
    for (int k = 0; k < 16; k++) begin
      b = k[2:0];
      s = k[3];
      t = mem_rdata_i[b];
      exec({b[0], b[1], b[2], s, 4'h3}, 8'h33, s ? 8'h80 : 8'h7f, ~t, 1'b1,
           1'b0);
      check_val(pc_next_o, (t != s) ? 12'h203 :
                s ? 12'h182 : 12'h281);
      check_val({carry_o, zero_o, seen_p[4], seen_p[7]},
                {t, 3'b111});
      check_val({ncyc[7:0], mem_addr_o}, 16'h0533);
    end
  endtask : t_btst

  task automatic t_bit();
    logic [2:0] b;
    logic       s;
    for (int k = 0; k < 16; k++) begin
      b = k[2:0];
      s = k[3];
      // Target a plain data byte, never a port or odd-access register
      exec({b[0], b[1], b[2], s, 4'hb}, 8'hc4, 8'h00, 1'b1, 1'b0,
           1'b0);
      check_val(mem_wdata_o, s ? mem_rdata_i | (8'h01 << b) :
                mem_rdata_i & ~(8'h01 << b));
      check_val({pc_next_o, ncyc[3:0], carry_o, zero_o, seen_p[4], seen_p[0]},
                {12'h202, 8'h49});
    end
  endtask : t_bit

  task automatic t_ctl();
    for (int k = 0; k < 6; k++) begin
      exec({(k == 5) ? 4'h3 : k[3:0], 4'hd}, 8'h00, 8'h00, 1'b0, 1'b0, k == 5);
      check_val({pc_next_o, ncyc[3:0], carry_o, zero_o},
                {(k == 1 || k == 2) ? 12'h3c7 : 12'h201, 4'h2,
                 (k == 2) ? 2'b11 : 2'b00});
      check_val(seen_p[5:2], {k == 1 || k == 2, k == 2, k > 3,
                k == 3});
    end
  endtask : t_ctl

  task automatic t_ext();
    for (int k = 0; k < 2; k++) begin
      exec({4'ha, k[0], 3'h1}, 8'h5c, 8'h00, 1'b1, 1'b1, 1'b0);
      check_val({pc_next_o, ncyc[3:0], carry_o, zero_o},
                {12'ha5c, 6'h13});
      // Push only for the call
      check_val({seen_p[1], push_addr_o}, {~k[0], 12'h202});
    end
  endtask : t_ext

  task automatic t_bad();
    exec(8'h07, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    check_val({ncyc[7:0], seen_p[6], busy_p, busy_o},
              {8'h02, 3'b110});
  endtask : t_bad

  // Reset, then every group in turn
  initial begin
    {bad_count, total_checks, cyc} = '0;
    {rst_n_i, start_i, carry_i, zero_i, watchdog_sel_i} = '0;
    {opcode_i, operand1_i, operand2_i} = '0;
    pc_i = 12'h200;
    mem_rdata_i = 8'h5a;
    ret_addr_i = 12'h3c7;
    {ret_carry_i, ret_zero_i} = 2'b11;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_rel();
    t_btst();
    t_bit();
    t_ctl();
    t_ext();
    t_bad();
    complete_run();
  end
endmodule : test_branch_bit_control_decode
